/* File: swg_top.sv */
// Purpose: Sine waveform generator with four setting registers and a sample FIFO.
// Assumes: mclk is the analog clock; enable, type and converter settings share it.
// Notes: The sine is a parabolic approximation, within about six percent of peak.
`timescale 1ns/1ps
`include "swg_map.svh"
module swg_top
    import swg_pkg::*;
#(
    parameter logic [`SWG_DIV_W-1:0] SAMPLE_DIV = `SWG_DIV_DEF,
    parameter int                    FIFO_DEPTH = `SWG_FIFO_DEPTH
) (
    input  wire logic                     mclk,
    input  wire logic                     rst_b,
    input  wire logic [`SWG_ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    output logic                          reg_ack,
    input  wire logic                     wavegen_enable,
    input  wire logic [`SWG_TYPE_W-1:0]   waveform_type_select,
    input  wire logic                     output_attenuation_enable,
    input  wire logic                     amp_gain_mode,
    output logic                          wave_active,
    output logic      [`SWG_CODE_W-1:0]   dac_code,
    output logic                          dac_atten,
    output logic                          dac_gain,
    output logic                          dac_valid,
    input  wire logic                     dac_ready
);
    localparam int WORD_W = `SWG_CODE_W + 2;

    swg_regs_t                r_reg;
    swg_regs_t                r_next;
    logic                     run_req;
    logic                     tick;
    logic                     push;
    logic                     push_ready;
    logic [`SWG_PH_W-1:0]     phase_sum;
    logic [`SWG_CODE_W-1:0]   raw_sine;
    logic [`SWG_CODE_W-1:0]   push_code;
    logic [WORD_W-1:0]        push_word;
    logic [WORD_W-1:0]        pop_word;

    // Address match shared by the write and read paths.
    function automatic logic swg_hit(input logic [`SWG_ADDR_W-1:0] a,
                                     input logic [`SWG_ADDR_W-1:0] off);
        return a == off;
    endfunction

    // Half-period parabola x*(H-x), scaled so the peak lands at full code.
    function automatic logic [`SWG_CODE_W-1:0] swg_sine(input logic [`SWG_PH_W-1:0] ph);
        logic [`SWG_PH_W-1:0]     x;
        logic [`SWG_PH_W-1:0]     rest;
        logic [2*`SWG_PH_W-1:0]   prod;
        logic [`SWG_CODE_W-1:0]   mag;
        x    = {1'b0, ph[`SWG_PH_W-2:0]};
        rest = `SWG_HALF_TURN - x;
        prod = x * rest;
        mag  = prod[`SWG_SIN_LSB+`SWG_CODE_W-1:`SWG_SIN_LSB];
        if (mag[`SWG_CODE_W-1]) begin
            mag = `SWG_CODE_MAX;
        end
        return ph[`SWG_PH_W-1] ? (~mag + 1'b1) : mag;
    endfunction

    // Scale by amplitude, add the signed offset and saturate to the code range.
    function automatic logic [`SWG_CODE_W-1:0] swg_shape(input logic [`SWG_CODE_W-1:0] s,
                                                         input logic [`SWG_AMP_W-1:0]  a,
                                                         input logic [`SWG_DC_W-1:0]   d);
        logic signed [2*`SWG_CODE_W-1:0] prod;
        logic signed [`SWG_CODE_W+1:0]   sum;
        prod = $signed(s) * $signed({1'b0, a});
        sum  = (`SWG_CODE_W+2)'(prod >>> `SWG_AMP_SHIFT) + (`SWG_CODE_W+2)'($signed(d));
        if (sum > $signed((`SWG_CODE_W+2)'($signed(`SWG_CODE_MAX)))) begin
            return `SWG_CODE_MAX;
        end
        if (sum < $signed({2'b11, `SWG_CODE_MIN})) begin
            return `SWG_CODE_MIN;
        end
        return sum[`SWG_CODE_W-1:0];
    endfunction

    // The generator runs only while enabled in sine mode.
    assign run_req = wavegen_enable && (waveform_type_select == `SWG_TYPE_SINE);

    // Sample pulse from the rate divider; it waits while the FIFO is full.
    assign tick = (r_reg.state == SWG_RUN) && (r_reg.div == SAMPLE_DIV - 1'b1);
    assign push = tick && run_req;

    // Phase offset joins the top twenty accumulator bits before the lookup.
    assign phase_sum = r_reg.acc[`SWG_ACC_W-1:`SWG_ACC_W-`SWG_PH_W] + r_reg.phase;
    assign raw_sine  = swg_sine(phase_sum);
    assign push_code = swg_shape(raw_sine, r_reg.amp, r_reg.dcoff);

    // Converter settings travel with each code so level follows all three.
    assign push_word = {amp_gain_mode, output_attenuation_enable, push_code};

    // Register file, read mux and the run control.
    always_comb begin
        r_next     = r_reg;
        r_next.ack = reg_wr || reg_rd;
        if (reg_wr) begin
            if (swg_hit(reg_addr, `SWG_OFF_FREQ)) begin
                r_next.fcw = reg_wdata[`SWG_FCW_W-1:0];
            end else if (swg_hit(reg_addr, `SWG_OFF_PHASE)) begin
                r_next.phase = reg_wdata[`SWG_PH_W-1:0];
            end else if (swg_hit(reg_addr, `SWG_OFF_DC)) begin
                r_next.dcoff = reg_wdata[`SWG_DC_W-1:0];
            end else if (swg_hit(reg_addr, `SWG_OFF_AMP)) begin
                r_next.amp = reg_wdata[`SWG_AMP_W-1:0];
            end
        end
        if (reg_rd) begin
            if (swg_hit(reg_addr, `SWG_OFF_FREQ)) begin
                r_next.rdata = 32'(r_reg.fcw);
            end else if (swg_hit(reg_addr, `SWG_OFF_PHASE)) begin
                r_next.rdata = 32'(r_reg.phase);
            end else if (swg_hit(reg_addr, `SWG_OFF_DC)) begin
                r_next.rdata = 32'(r_reg.dcoff);
            end else if (swg_hit(reg_addr, `SWG_OFF_AMP)) begin
                r_next.rdata = 32'(r_reg.amp);
            end else begin
                r_next.rdata = `SWG_RST_WORD;
            end
        end
        case (r_reg.state)
            SWG_IDLE: begin
                // Clearing the accumulator here makes every start begin at the offset.
                r_next.acc = '0;
                r_next.div = '0;
                if (run_req) begin
                    r_next.state = SWG_RUN;
                end
            end
            SWG_RUN: begin
                if (!run_req) begin
                    r_next.state = SWG_IDLE;
                    r_next.acc   = '0;
                    r_next.div   = '0;
                end else begin
                    // Modulo 2^30 wrap gives fout = fclk * word / 2^30.
                    r_next.acc = r_reg.acc + r_reg.fcw[`SWG_ACC_W-1:0];
                    if (!tick) begin
                        r_next.div = r_reg.div + 1'b1;
                    end else if (push_ready) begin
                        r_next.div = '0;
                    end
                end
            end
            default: begin
                r_next.state = SWG_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // Samples queue here so the converter stage may stall without losing codes.
    swg_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (dac_valid),
        .out_ready (dac_ready),
        .out_data  (pop_word)
    );

    assign dac_code    = pop_word[`SWG_CODE_W-1:0];
    assign dac_atten   = pop_word[`SWG_CODE_W];
    assign dac_gain    = pop_word[`SWG_CODE_W+1];
    assign reg_rdata   = r_reg.rdata;
    assign reg_ack     = r_reg.ack;
    assign wave_active = (r_reg.state == SWG_RUN);

    // Checks on the generator itself.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    logic [`SWG_CODE_W-1:0] code_abs;
    assign code_abs = push_code[`SWG_CODE_W-1] ? (~push_code + 1'b1) : push_code;

    sequence s_start;
        (r_reg.state == SWG_IDLE) ##1 (r_reg.state == SWG_RUN);
    endsequence

    sequence s_running;
        (r_reg.state == SWG_RUN && run_req) [*2];
    endsequence

    a_acc_step: assert property (s_running |->
        r_reg.acc == $past(r_reg.acc) + $past(r_reg.fcw[`SWG_ACC_W-1:0]))
        else $error("Accumulator did not advance by the control word.");

    a_start_phase: assert property (s_start |-> phase_sum == r_reg.phase)
        else $error("First phase after start is not the phase offset.");

    // The most negative offset saturates to the symmetric code floor.
    a_dc_only: assert property (push && r_reg.amp == '0 |->
        push_code == (($signed(r_reg.dcoff) < $signed(`SWG_CODE_MIN)) ?
                      `SWG_CODE_MIN : r_reg.dcoff))
        else $error("Zero amplitude code differs from the offset.");

    a_amp_bound: assert property (push && r_reg.dcoff == '0 |->
        {1'b0, code_abs} <= {2'b00, r_reg.amp})
        else $error("Code magnitude exceeds the amplitude.");

    // A push into an empty queue must show at the converter side one cycle later.
    a_flag_carry: assert property (push && push_ready && !dac_valid |=>
        dac_valid && {dac_gain, dac_atten, dac_code} ==
        {$past(amp_gain_mode), $past(output_attenuation_enable), $past(push_code)})
        else $error("Converter settings not carried with the code.");

    a_idle_reset: assert property (r_reg.state == SWG_IDLE |->
        !push ##1 r_reg.acc == '0)
        else $error("Accumulator not cleared or sample pushed while idle.");

    a_tick_space: assert property (push && push_ready |=> !push [*2])
        else $error("Sample pulses closer than the divider allows.");

    a_reg_ack: assert property ((reg_wr || reg_rd) |=> reg_ack)
        else $error("Register access not acknowledged.");
endmodule

/* File: swg_map.svh */
// Purpose: Register map and fixed constants of the sine waveform generator.
// Assumes: Included by the package and the generator top.
// Notes: Offsets are byte addresses on the internal register port.
// Behaviour
// - Output frequency is clock times word over 2^30.
// - Twenty-bit phase offset sets the starting phase.
// - Signed twelve-bit offset added to every sample.
// - Unsigned eleven-bit amplitude scales the waveform.
// - Converter level follows amplitude, attenuation and gain.
`ifndef SWG_MAP_SVH
`define SWG_MAP_SVH
`define SWG_ADDR_W      16
`define SWG_OFF_FREQ    16'h2030
`define SWG_OFF_PHASE   16'h2034
`define SWG_OFF_DC      16'h2038
`define SWG_OFF_AMP     16'h203c
`define SWG_RST_WORD    32'h0000_0000
`define SWG_FCW_W       31
`define SWG_PH_W        20
`define SWG_DC_W        12
`define SWG_AMP_W       11
`define SWG_ACC_W       30
`define SWG_CODE_W      12
`define SWG_TYPE_W      2
`define SWG_TYPE_SINE   2'h2
`define SWG_HALF_TURN   20'h80000
`define SWG_SIN_LSB     25
`define SWG_AMP_SHIFT   11
`define SWG_CODE_MAX    12'h7ff
`define SWG_CODE_MIN    12'h801
`define SWG_DIV_W       16
`define SWG_DIV_DEF     16'h0020
`define SWG_FIFO_DEPTH  4
`endif

/* File: swg_pkg.sv */
// Purpose: Types shared by the sine waveform generator.
// Assumes: The map header supplies all widths but those of the state, read data and acknowledge.
// Notes: One packed struct holds the whole generator state.
`include "swg_map.svh"
package swg_pkg;
    typedef enum logic [0:0] {
        SWG_IDLE = 1'b0,
        SWG_RUN  = 1'b1
    } swg_state_t;

    typedef struct packed {
        swg_state_t                state;
        logic [`SWG_ACC_W-1:0]     acc;
        logic [`SWG_FCW_W-1:0]     fcw;
        logic [`SWG_PH_W-1:0]      phase;
        logic [`SWG_DC_W-1:0]      dcoff;
        logic [`SWG_AMP_W-1:0]     amp;
        logic [`SWG_DIV_W-1:0]     div;
        logic [31:0]               rdata;
        logic                      ack;
    } swg_regs_t;
endpackage

/* File: swg_fifo.sv */
// Purpose: Small sample FIFO between the generator and the converter stage.
// Assumes: Single clock; in_ready low when full, out_valid low when empty.
// Notes: A push and a pop in the same cycle are both honoured when neither empty nor full.
`timescale 1ns/1ps
module swg_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } swg_fifo_t;

    swg_fifo_t        fifo_reg;
    swg_fifo_t        fifo_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             do_push;
    logic             do_pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (fifo_reg.count != (AW+1)'(DEPTH));
    assign out_valid = (fifo_reg.count != '0);
    assign out_data  = mem[fifo_reg.rd_ptr];
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    // Pointers wrap at DEPTH so that depths other than powers of two work.
    always_comb begin
        fifo_next = fifo_reg;
        if (do_push) begin
            fifo_next.wr_ptr = (fifo_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : fifo_reg.wr_ptr + 1'b1;
        end
        if (do_pop) begin
            fifo_next.rd_ptr = (fifo_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : fifo_reg.rd_ptr + 1'b1;
        end
        if (do_push && !do_pop) begin
            fifo_next.count = fifo_reg.count + 1'b1;
        end else if (do_pop && !do_push) begin
            fifo_next.count = fifo_reg.count - 1'b1;
        end
    end

    // The storage array has no reset; it is only read where count says valid.
    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[fifo_reg.wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end
endmodule

/* File: swg_dac_model.sv */
// Purpose: Behavioural converter stage that takes samples from the generator.
// Assumes: A sample passes on a rising edge with dac_valid and dac_ready high.
// Notes: Stall holds ready low so the sample FIFO fills; captures go to a queue.
`timescale 1ns/1ps
module swg_dac_model (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        stall,
    input  wire logic [11:0] dac_code,
    input  wire logic        dac_atten,
    input  wire logic        dac_gain,
    input  wire logic        dac_valid,
    output logic             dac_ready
);
    logic [13:0] got[$];

    // Ready is the inverse of stall one cycle late, as a busy converter would.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dac_ready <= 1'b0;
        end else begin
            dac_ready <= !stall;
        end
    end

    // Level, attenuation and gain are taken as one word, since they set the output together.
    always @(posedge mclk) begin
        if (rst_b && dac_valid && dac_ready) begin
            got.push_back({dac_gain, dac_atten, dac_code});
        end
    end
endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for the sine waveform generator.
// Assumes: Sample divider shortened to 4 so each run takes a few dozen cycles.
// Notes: Expected codes come from the parabolic sine formula of the generator.
`timescale 1ns/1ps
module tb_top;
    localparam int SDIV = 4;
    logic        mclk;
    logic        rst_b;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        reg_ack;
    logic        wavegen_enable;
    logic [1:0]  waveform_type_select;
    logic        output_attenuation_enable;
    logic        amp_gain_mode;
    logic        wave_active;
    logic [11:0] dac_code;
    logic        dac_atten;
    logic        dac_gain;
    logic        dac_valid;
    logic        dac_ready;
    logic        stall;
    int          fails;
    int          n_tests;
    int          cycles;
    logic [31:0] mask [4] = '{32'h7fff_ffff, 32'h000f_ffff, 32'h0000_0fff, 32'h0000_07ff};

    swg_top #(.SAMPLE_DIV(16'(SDIV)), .FIFO_DEPTH(4)) i_swg_top (
        .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .wavegen_enable(wavegen_enable), .waveform_type_select(waveform_type_select),
        .output_attenuation_enable(output_attenuation_enable),
        .amp_gain_mode(amp_gain_mode), .wave_active(wave_active), .dac_code(dac_code),
        .dac_atten(dac_atten), .dac_gain(dac_gain), .dac_valid(dac_valid),
        .dac_ready(dac_ready));

    swg_dac_model i_swg_dac_model (
        .mclk(mclk), .rst_b(rst_b), .stall(stall), .dac_code(dac_code),
        .dac_atten(dac_atten), .dac_gain(dac_gain), .dac_valid(dac_valid),
        .dac_ready(dac_ready));

    // Free-running 50 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short; the ceiling is more than ten times the expected run.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One strobe per access; the acknowledge comes exactly one cycle after it.
    task automatic acc_reg(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 chk({31'h0, reg_ack}, 32'h1);
    endtask

    task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
        acc_reg(1'b0, a, 32'h0);
        chk(reg_rdata, exp);
    endtask

    // Parabolic sine, scaled by amplitude, shifted by offset, saturated symmetrically.
    function automatic logic [11:0] exp_code(input logic [19:0] p, input logic [10:0] a,
                                             input logic [11:0] d);
        longint m;
        longint v;
        m = (longint'(p[18:0]) * (longint'(524288) - longint'(p[18:0]))) >>> 25;
        m = (m > 2047) ? 2047 : m;
        m = p[19] ? -m : m;
        v = ((m * longint'(a)) >>> 11) + longint'($signed(d));
        v = (v > 2047) ? 2047 : ((v < -2047) ? -2047 : v);
        return v[11:0];
    endfunction

    // Settings are loaded before the sine type and enable are applied.
    task automatic run(input logic [31:0] f, p, d, a, input logic at, gn, input int n);
        logic [29:0] acc;
        logic [19:0] ph;
        int          w;
        i_swg_dac_model.got.delete();
        acc_reg(1'b1, 16'h2034, p);
        acc_reg(1'b1, 16'h2038, d);
        acc_reg(1'b1, 16'h203c, a);
        acc_reg(1'b1, 16'h2030, f);
        @(posedge mclk);
        output_attenuation_enable <= at;
        amp_gain_mode <= gn;
        waveform_type_select <= 2'h2;
        wavegen_enable <= 1'b1;
        w = 0;
        while (i_swg_dac_model.got.size() < n && w < 300) begin
            @(posedge mclk);
            w++;
        end
        #1 chk({31'h0, wave_active}, 32'h1);
        chk({31'h0, i_swg_dac_model.got.size() >= n}, 32'h1);
        @(posedge mclk);
        wavegen_enable <= 1'b0;
        repeat (12) @(posedge mclk);
        #1 chk({31'h0, wave_active}, 32'h0);
        for (int k = 0; k < n; k++) begin
            acc = f[29:0] * 30'(SDIV - 1 + k * SDIV);
            ph = acc[29:10] + p[19:0];
            chk(32'(i_swg_dac_model.got[k]), {18'h0, gn, at, exp_code(ph, a[10:0], d[11:0])});
        end
    endtask

    // Main sequence: registers, stopped modes, sample runs, then buffering.
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, wavegen_enable} = '0;
        {waveform_type_select, output_attenuation_enable, amp_gain_mode, stall} = '0;
        {fails, n_tests, cycles} = '0;
        rst_b = 1'b0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rchk(16'h2030 + 16'(4 * i), 32'h0);
            acc_reg(1'b1, 16'h2030 + 16'(4 * i), 32'hffff_ffff);
            rchk(16'h2030 + 16'(4 * i), mask[i]);
        end
        acc_reg(1'b1, 16'h2040, 32'hffff_ffff);
        rchk(16'h2040, 32'h0);
        rchk(16'h2020, 32'h0);
        for (int t = 0; t < 4; t++) begin
            @(posedge mclk);
            // The last pass holds the sine code with the enable low.
            waveform_type_select <= (t >= 2) ? 2'(5 - t) : 2'(t);
            wavegen_enable <= (t != 3);
            repeat (20) @(posedge mclk);
            #1 chk({30'h0, wave_active, dac_valid}, 32'h0);
        end
        run(32'h0, 32'h4_0000, 32'h0, 32'h7ff, 1'b1, 1'b0, 3);
        run(32'h0, 32'hc_0000, 32'h0, 32'h3ff, 1'b0, 1'b1, 3);
        run(32'h0, 32'h4_0000, 32'h064, 32'h7ff, 1'b0, 1'b1, 3);
        run(32'h0, 32'h0, 32'h800, 32'h0, 1'b1, 1'b1, 3);
        run(32'h4400_0000, 32'h1_0000, 32'hf9c, 32'h400, 1'b0, 1'b0, 6);
        i_swg_dac_model.got.delete();
        @(posedge mclk);
        stall <= 1'b1;
        wavegen_enable <= 1'b1;
        repeat (60) @(posedge mclk);
        #1 chk({31'h0, dac_valid}, 32'h1);
        @(posedge mclk);
        wavegen_enable <= 1'b0;
        stall <= 1'b0;
        repeat (20) @(posedge mclk);
        #1 chk(32'(i_swg_dac_model.got.size()), 32'h4);
        chk({31'h0, dac_valid}, 32'h0);
        wrap_up();
    end
endmodule
